// ### logic/supply_monitor_pkg.sv
// Shared constants and types of the supply monitor control block
package supply_monitor_pkg;
	// Register offsets on the plain register port
	localparam logic [3:0] OFS_CLOCK_CTRL = 4'h0;
	localparam logic [3:0] OFS_DETECT_CTRL = 4'h2;
	localparam logic [3:0] OFS_FLAGS = 4'h4;
	localparam logic [3:0] OFS_IRQ_EN = 4'h6;
	localparam logic [3:0] OFS_PROTECT = 4'h8;
	// Clock control fields
	localparam int POS_DEBUG_RUN = 8;
	localparam int POS_CLK_DIV = 4;
	localparam int POS_CLK_SRC = 0;
	// Detector control fields
	localparam int POS_SUCC_CNT = 13;
	localparam int POS_THRESH = 8;
	localparam int POS_RST_SEL = 4;
	localparam int POS_OP_MODE = 1;
	localparam int POS_ENABLE = 0;
	// Flag register fields
	localparam int POS_RESULT = 8;
	localparam int POS_FLAG = 0;
	// Reset values
	localparam logic RST_DEBUG_RUN = 1'b1;
	localparam logic [2:0] RST_CLK_DIV = 3'h0;
	localparam logic [1:0] RST_CLK_SRC = 2'h0;
	localparam logic [1:0] RST_SUCC_CNT = 2'h0;
	localparam logic [4:0] RST_THRESH = 5'h1E;
	localparam logic [3:0] RST_RST_SEL = 4'h0;
	localparam logic [1:0] RST_OP_MODE = 2'h0;
	// Codes
	localparam logic [15:0] PROTECT_KEY = 16'h0096;
	localparam logic [3:0] RST_SEL_RESET = 4'hA;
	localparam logic [1:0] MODE_CONTINUOUS = 2'h0;
	// Detector clock divider: ratio 4 << select, selects at or above this pass through
	localparam logic [2:0] CLK_DIV_BYPASS = 3'h6;
	localparam logic [7:0] CLK_DIV_BASE = 8'h04;
	// Intermittent base interval in detector ticks, doubled per mode step
	localparam logic [9:0] INTERVAL_BASE = 10'h080;
	// Timing in detector ticks; settle must outlast the two-flop sync at one tick a cycle
	localparam logic [9:0] MASK_TICKS = 10'h002;
	localparam logic [9:0] SETTLE_TICKS = 10'h003;
	// Detector drain after disable, in ns, then in system clock cycles
	localparam int CLK_PERIOD_NS = 50;
	localparam int DRAIN_NS = 100;
	localparam int DRAIN_CYC = (DRAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		ST_OFF, ST_MASK, ST_RUN, ST_WAIT, ST_SETTLE, ST_DRAIN
	} detect_state_t;
endpackage

// ### logic/detector_tick_gen.sv
// Detector clock enable derived from the system clock by the selected ratio
`timescale 1ns/1ps
module detector_tick_gen
	import supply_monitor_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Control
	input wire logic [2:0] div_sel,
	input wire logic run,
	// Tick
	output logic tick
);
	typedef struct packed {
		logic [7:0] cnt;
	} tick_state_t;
	tick_state_t s_ff, nxt_s;
	logic [7:0] ratio;

	always_comb begin
		nxt_s = s_ff;
		ratio = (div_sel >= CLK_DIV_BYPASS) ? 8'h01 : 8'(CLK_DIV_BASE << div_sel);
		tick = run && (s_ff.cnt >= ratio - 8'h01);
		// Counter freezes while gated so the phase survives a debug halt
		if (run) begin
			nxt_s.cnt = tick ? 8'h00 : s_ff.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule

// ### logic/low_run_counter.sv
// Counter of consecutive low detections in intermittent mode
`timescale 1ns/1ps
module low_run_counter
	import supply_monitor_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Control
	input wire logic clear,
	input wire logic sample,
	input wire logic low,
	input wire logic [1:0] count_sel,
	// Result
	output logic reached
);
	typedef struct packed {
		logic [3:0] cnt;
	} run_state_t;
	run_state_t s_ff, nxt_s;
	logic [3:0] target;

	always_comb begin
		nxt_s = s_ff;
		target = 4'(4'h1 << count_sel);
		reached = sample && low && !clear && (s_ff.cnt + 4'h1 >= target);
		if (clear || (sample && !low) || reached) begin
			nxt_s.cnt = 4'h0;
		end else if (sample && low) begin
			nxt_s.cnt = s_ff.cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule

// ### logic/supply_monitor_ctrl.sv
// Supply monitor control: registers, detection sequencing, flag and reset request
`timescale 1ns/1ps
module supply_monitor_ctrl
	import supply_monitor_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Analogue comparator
	input wire logic cmp_low_async,
	output logic cmp_enable,
	output logic [4:0] threshold_select,
	// Processor and system
	input wire logic debug_mode,
	output logic [1:0] clock_source_select,
	output logic low_voltage_irq,
	output logic sys_reset_req
);
	typedef struct packed {
		logic cmp_meta;
		logic cmp_sync;
		logic [15:0] prot_key;
		logic debug_run;
		logic [2:0] clk_div;
		logic [1:0] clk_src;
		logic [1:0] succ_cnt;
		logic [4:0] thresh;
		logic [3:0] rst_sel;
		logic [1:0] op_mode;
		logic enable;
		logic result;
		logic flag;
		logic irq_en;
		logic rst_state;
		detect_state_t st;
		logic [9:0] tcnt;
		logic [15:0] rdata;
	} ctrl_state_t;
	ctrl_state_t s_ff, nxt_s;
	logic tick;
	logic unlocked;
	logic wr_clk, wr_ctl, wr_flags, wr_irq;
	logic ctl_changed;
	logic sample;
	logic run_clear;
	logic reached;
	logic low_event;
	logic [9:0] interval;
	logic [15:0] rd_mux;

	// Stopped detector clock freezes every detector step but the drain, which counts system clock cycles
	detector_tick_gen u_tick (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.div_sel(s_ff.clk_div),
		.run(!(debug_mode && !s_ff.debug_run)),
		.tick(tick)
	);

	low_run_counter u_run (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clear(run_clear),
		.sample(sample),
		.low(s_ff.cmp_sync),
		.count_sel(s_ff.succ_cnt),
		.reached(reached)
	);

	always_comb begin
		nxt_s = s_ff;
		nxt_s.cmp_meta = cmp_low_async;
		nxt_s.cmp_sync = s_ff.cmp_meta;
		unlocked = (s_ff.prot_key == PROTECT_KEY);
		wr_clk = reg_wr && unlocked && (reg_addr == OFS_CLOCK_CTRL);
		wr_ctl = reg_wr && unlocked && (reg_addr == OFS_DETECT_CTRL);
		wr_flags = reg_wr && (reg_addr == OFS_FLAGS);
		wr_irq = reg_wr && (reg_addr == OFS_IRQ_EN);
		ctl_changed = wr_ctl && (reg_wdata[POS_SUCC_CNT +: 2] != s_ff.succ_cnt
			|| reg_wdata[POS_RST_SEL +: 4] != s_ff.rst_sel
			|| reg_wdata[POS_OP_MODE +: 2] != s_ff.op_mode);
		interval = 10'(INTERVAL_BASE << (s_ff.op_mode - 2'h1));
		sample = 1'b0;
		run_clear = 1'b0;
		low_event = 1'b0;

		// Register writes
		if (reg_wr && reg_addr == OFS_PROTECT) begin
			nxt_s.prot_key = reg_wdata;
		end
		if (wr_clk) begin
			nxt_s.debug_run = reg_wdata[POS_DEBUG_RUN];
			nxt_s.clk_div = reg_wdata[POS_CLK_DIV +: 3];
			nxt_s.clk_src = reg_wdata[POS_CLK_SRC +: 2];
		end
		if (wr_ctl) begin
			nxt_s.succ_cnt = reg_wdata[POS_SUCC_CNT +: 2];
			nxt_s.thresh = reg_wdata[POS_THRESH +: 5];
			nxt_s.rst_sel = reg_wdata[POS_RST_SEL +: 4];
			nxt_s.op_mode = reg_wdata[POS_OP_MODE +: 2];
		end
		if (wr_irq) begin
			nxt_s.irq_en = reg_wdata[0];
		end
		if (wr_flags && reg_wdata[POS_FLAG]) begin
			nxt_s.flag = 1'b0;
		end

		// Detection sequencing
		case (s_ff.st)
			ST_OFF: begin
				run_clear = 1'b1;
				if (wr_ctl && reg_wdata[POS_ENABLE]) begin
					nxt_s.enable = 1'b1;
					nxt_s.st = ST_MASK;
					nxt_s.tcnt = '0;
				end
			end
			ST_MASK: begin
				// Results are ignored until the comparator has settled
				if (tick) begin
					nxt_s.tcnt = s_ff.tcnt + 10'h001;
					if (s_ff.tcnt + 10'h001 >= MASK_TICKS) begin
						nxt_s.tcnt = '0;
						nxt_s.st = (s_ff.op_mode == MODE_CONTINUOUS) ? ST_RUN : ST_WAIT;
					end
				end
			end
			ST_RUN: begin
				if (tick) begin
					nxt_s.result = s_ff.cmp_sync;
					low_event = s_ff.cmp_sync;
				end
			end
			ST_WAIT: begin
				if (tick) begin
					nxt_s.tcnt = s_ff.tcnt + 10'h001;
					if (s_ff.tcnt + 10'h001 >= interval - SETTLE_TICKS) begin
						nxt_s.tcnt = '0;
						nxt_s.st = ST_SETTLE;
					end
				end
			end
			ST_SETTLE: begin
				if (tick) begin
					nxt_s.tcnt = s_ff.tcnt + 10'h001;
					if (s_ff.tcnt + 10'h001 >= SETTLE_TICKS) begin
						nxt_s.tcnt = '0;
						nxt_s.st = ST_WAIT;
						nxt_s.result = s_ff.cmp_sync;
						sample = 1'b1;
						low_event = reached;
					end
				end
			end
			ST_DRAIN: begin
				run_clear = 1'b1;
				if (s_ff.tcnt == 10'h000) begin
					nxt_s.enable = 1'b0;
					nxt_s.st = ST_OFF;
				end else begin
					nxt_s.tcnt = s_ff.tcnt - 10'h001;
				end
			end
			default: begin
				nxt_s.st = ST_OFF;
			end
		endcase

		// Reinitialise on a mode change or a flag clear while enabled
		if (s_ff.enable && s_ff.st != ST_DRAIN && s_ff.st != ST_OFF) begin
			if (wr_ctl && !reg_wdata[POS_ENABLE] && !s_ff.rst_state) begin
				nxt_s.st = ST_DRAIN;
				nxt_s.tcnt = 10'(DRAIN_CYC - 1);
				low_event = 1'b0;
			end else if (ctl_changed || (wr_flags && reg_wdata[POS_FLAG])) begin
				nxt_s.st = ST_MASK;
				nxt_s.tcnt = '0;
				run_clear = 1'b1;
			end
		end

		// Low detection: flag set wins over a same-cycle clear only in ST_RUN; in ST_SETTLE the clear wins
		if (low_event) begin
			nxt_s.flag = 1'b1;
			if (s_ff.rst_sel == RST_SEL_RESET) begin
				nxt_s.rst_state = 1'b1;
				nxt_s.st = ST_RUN;
				nxt_s.tcnt = '0;
			end
		end else if (s_ff.rst_state && s_ff.st == ST_RUN && tick && !s_ff.cmp_sync) begin
			nxt_s.rst_state = 1'b0;
		end

		// Reset state forces defined values on the control bits, all but the threshold
		if (nxt_s.rst_state) begin
			nxt_s.debug_run = RST_DEBUG_RUN;
			nxt_s.clk_div = RST_CLK_DIV;
			nxt_s.clk_src = RST_CLK_SRC;
			nxt_s.succ_cnt = RST_SUCC_CNT;
			nxt_s.op_mode = MODE_CONTINUOUS;
			nxt_s.irq_en = 1'b0;
			nxt_s.rst_sel = RST_SEL_RESET;
			nxt_s.enable = 1'b1;
			nxt_s.flag = 1'b1;
		end

		// Read data, one cycle after the strobe
		case (reg_addr)
			OFS_CLOCK_CTRL: rd_mux = {7'h00, s_ff.debug_run, 1'b0, s_ff.clk_div,
				2'h0, s_ff.clk_src};
			OFS_DETECT_CTRL: rd_mux = {1'b0, s_ff.succ_cnt, s_ff.thresh, s_ff.rst_sel,
				1'b0, s_ff.op_mode, s_ff.enable};
			OFS_FLAGS: rd_mux = {7'h00, s_ff.result, 7'h00, s_ff.flag};
			OFS_IRQ_EN: rd_mux = {15'h0000, s_ff.irq_en};
			OFS_PROTECT: rd_mux = {15'h0000, unlocked};
			default: rd_mux = 16'h0000;
		endcase
		nxt_s.rdata = reg_rd ? rd_mux : 16'h0000;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_ff <= '0;
			s_ff.debug_run <= RST_DEBUG_RUN;
			s_ff.clk_div <= RST_CLK_DIV;
			s_ff.clk_src <= RST_CLK_SRC;
			s_ff.succ_cnt <= RST_SUCC_CNT;
			s_ff.thresh <= RST_THRESH;
			s_ff.rst_sel <= RST_RST_SEL;
			s_ff.op_mode <= RST_OP_MODE;
			s_ff.st <= ST_OFF;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign reg_rdata = s_ff.rdata;
	assign cmp_enable = (s_ff.st == ST_MASK) || (s_ff.st == ST_RUN) || (s_ff.st == ST_SETTLE);
	assign threshold_select = s_ff.thresh;
	assign clock_source_select = s_ff.clk_src;
	assign low_voltage_irq = s_ff.flag && s_ff.irq_en;
	assign sys_reset_req = s_ff.rst_state;

	// Checks
	sequence disable_write_s;
		wr_ctl && !reg_wdata[POS_ENABLE] && s_ff.enable && !s_ff.rst_state
			&& s_ff.st != ST_DRAIN && s_ff.st != ST_OFF;
	endsequence
	sequence drain_done_s;
		s_ff.enable [*2] ##1 !s_ff.enable;
	endsequence

	a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_irq && s_ff.flag && s_ff.rst_sel != RST_SEL_RESET
			|=> low_voltage_irq == $past(reg_wdata[0]))
		else $error("interrupt request did not follow its enable");
	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_ff.flag && !(wr_flags && reg_wdata[POS_FLAG]) |=> s_ff.flag)
		else $error("flag dropped without a software clear");
	a_drain_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
		disable_write_s |=> drain_done_s)
		else $error("enable did not read 0 after the drain");
	a_reset_forces: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_ff.rst_state |-> s_ff.op_mode == 2'h0 && s_ff.succ_cnt == 2'h0
			&& !s_ff.irq_en && s_ff.debug_run && s_ff.clk_div == 3'h0)
		else $error("reset state control bits not forced");
	a_reset_retains: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_ff.rst_state |-> s_ff.enable && s_ff.flag && s_ff.rst_sel == 4'hA)
		else $error("reset state lost a retained bit");
	a_reset_with_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(s_ff.rst_state) |-> s_ff.flag && $past(s_ff.rst_sel) == 4'hA)
		else $error("reset issued without the flag or selection");
	a_cont_after_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(s_ff.rst_state) |-> s_ff.st == ST_RUN && cmp_enable)
		else $error("detector not continuous after reset");
	a_reset_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_ff.rst_state && s_ff.st == ST_RUN && tick && !s_ff.cmp_sync |=> !s_ff.rst_state)
		else $error("reset state held after supply recovered");
	a_result_update: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_ff.st == ST_RUN && tick |=> s_ff.result == $past(s_ff.cmp_sync))
		else $error("continuous result not loaded");
	a_sleep_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_ff.st == ST_WAIT |-> !cmp_enable)
		else $error("comparator powered between detections");
	a_reinit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctl_changed && reg_wdata[POS_ENABLE] && !low_event
			&& (s_ff.st == ST_RUN || s_ff.st == ST_WAIT) |=> s_ff.st == ST_MASK)
		else $error("mode change did not reinitialise");
	a_lock_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && reg_addr == OFS_DETECT_CTRL && !unlocked && !s_ff.rst_state
			|=> s_ff.thresh == $past(s_ff.thresh))
		else $error("protected write took effect while locked");
endmodule

// ### sim/supply_comparator_model.sv
// Behavioural comparator on the monitored supply, prompt or slow
`timescale 1ns/1ps
module supply_comparator_model (
	// Clock
	input wire logic clk_sys,
	// From the block and the bench
	input wire logic cmp_enable,
	input wire logic [4:0] threshold_select,
	input wire logic [4:0] supply_level,
	input wire logic slow,
	// Comparator output
	output logic cmp_low_async
);
	logic [3:0] delay_ff;
	logic wander_ff;
	logic low_now;
	initial delay_ff = 4'h0;
	initial wander_ff = 1'b0;
	assign low_now = supply_level < threshold_select;
	// Powered down it wanders, so a stale level never passes for a result
	assign cmp_low_async = !cmp_enable ? wander_ff : (slow ? delay_ff[3] : low_now);
	always @(posedge clk_sys) begin
		delay_ff <= {delay_ff[2:0], low_now};
		wander_ff <= ~wander_ff;
	end
endmodule

// ### sim/supply_voltage_monitor_ctrl_bench.sv
// Self-checking bench of the supply monitor control block
`timescale 1ns/1ps
module supply_voltage_monitor_ctrl_bench
	import supply_monitor_pkg::*;
();
	logic clk_sys, rst_n, reg_wr, reg_rd, cmp_low_async, cmp_enable, debug_mode;
	logic low_voltage_irq, sys_reset_req, slow;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rv;
	logic [4:0] threshold_select, supply_level;
	logic [1:0] clock_source_select;
	int errors, total_checks, n;
	typedef struct {logic do_wr; logic [3:0] addr; logic [15:0] wdata; logic [15:0] exp;} row_t;
	row_t rows[13];

	supply_monitor_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cmp_low_async(cmp_low_async), .cmp_enable(cmp_enable),
		.threshold_select(threshold_select), .debug_mode(debug_mode),
		.clock_source_select(clock_source_select), .low_voltage_irq(low_voltage_irq),
		.sys_reset_req(sys_reset_req));
	supply_comparator_model cmp_u (.clk_sys(clk_sys), .cmp_enable(cmp_enable),
		.threshold_select(threshold_select), .supply_level(supply_level), .slow(slow),
		.cmp_low_async(cmp_low_async));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		rv = reg_rdata;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_sys);
	endtask
	// Cycles until cmp_enable next reaches lvl from the other level
	task automatic edge_wait(input logic lvl, input int lim);
		n = 0;
		while (cmp_enable === lvl && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		while (cmp_enable !== lvl && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask
	task automatic wait_req(input logic lvl, input int lim);
		n = 0;
		while (sys_reset_req !== lvl && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// About 5000 cycles are needed; six times that means a hang
	initial begin
		repeat (30000) @(posedge clk_sys);
		errors++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test;
	end

	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		debug_mode = 1'b0;
		slow = 1'b0;
		supply_level = 5'h18;
		errors = 0;
		total_checks = 0;
		rows = '{'{1'b0, 4'h0, 16'h0000, 16'h0100}, '{1'b0, 4'h2, 16'h0000, 16'h1E00},
			'{1'b0, 4'h4, 16'h0000, 16'h0000}, '{1'b0, 4'h6, 16'h0000, 16'h0000},
			'{1'b0, 4'h8, 16'h0000, 16'h0000}, '{1'b1, 4'h0, 16'hFFFF, 16'h0100},
			'{1'b1, 4'h2, 16'hFFFF, 16'h1E00}, '{1'b1, 4'h8, 16'h0096, 16'h0001},
			'{1'b1, 4'h0, 16'hFFFF, 16'h0173}, '{1'b1, 4'h0, 16'h0060, 16'h0060},
			'{1'b1, 4'h6, 16'hFFFF, 16'h0001}, '{1'b1, 4'hA, 16'hFFFF, 16'h0000},
			'{1'b1, 4'h6, 16'h0000, 16'h0000}};
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].do_wr)
				wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr);
			chk(rv, rows[i].exp);
		end
		$display("register table done");

		wr(OFS_IRQ_EN, 16'h0001);
		wr(OFS_DETECT_CTRL, 16'h1001);
		cyc(20);
		chk({11'h000, threshold_select}, 16'h0010);
		rd(OFS_FLAGS);
		chk(rv, 16'h0000);
		@(posedge clk_sys);
		slow <= 1'b1;
		supply_level <= 5'h08;
		cyc(20);
		rd(OFS_FLAGS);
		chk(rv, 16'h0101);
		chk({15'h0000, low_voltage_irq}, 16'h0001);
		@(posedge clk_sys);
		supply_level <= 5'h18;
		cyc(20);
		rd(OFS_FLAGS);
		chk(rv, 16'h0001);
		wr(OFS_IRQ_EN, 16'h0000);
		@(negedge clk_sys);
		chk({15'h0000, low_voltage_irq}, 16'h0000);
		wr(OFS_FLAGS, 16'h0001);
		cyc(20);
		rd(OFS_FLAGS);
		chk(rv, 16'h0000);
		wr(OFS_DETECT_CTRL, 16'h1901);
		cyc(20);
		rd(OFS_FLAGS);
		chk(rv, 16'h0101);
		$display("continuous test done");

		wr(OFS_CLOCK_CTRL, 16'h0061);
		wr(OFS_IRQ_EN, 16'h0001);
		wr(OFS_DETECT_CTRL, 16'h30A3);
		@(posedge clk_sys);
		supply_level <= 5'h08;
		wait_req(1'b1, 1000);
		// A single low sample would fire near 130 cycles
		chk(16'(n > 140 && n < 1000), 16'h0001);
		rd(OFS_FLAGS);
		chk(rv, 16'h0101);
		rd(OFS_DETECT_CTRL);
		chk(rv, 16'h10A1);
		rd(OFS_CLOCK_CTRL);
		chk(rv, 16'h0100);
		rd(OFS_IRQ_EN);
		chk(rv, 16'h0000);
		chk({14'h0000, clock_source_select}, 16'h0000);
		@(posedge clk_sys);
		supply_level <= 5'h18;
		wait_req(1'b0, 200);
		chk(16'(n < 200), 16'h0001);
		rd(OFS_FLAGS);
		chk(rv, 16'h0001);
		$display("reset function test done");

		wr(OFS_CLOCK_CTRL, 16'h0060);
		for (int m = 1; m < 4; m++) begin
			wr(OFS_DETECT_CTRL, 16'h1001 | (16'(m) << 1));
			edge_wait(1'b1, 2000);
			edge_wait(1'b1, 2000);
			chk(16'(n), 16'(INTERVAL_BASE) << (m - 1));
		end
		$display("interval test done");

		wr(OFS_FLAGS, 16'h0001);
		wr(OFS_DETECT_CTRL, 16'h7003);
		@(posedge clk_sys);
		supply_level <= 5'h08;
		repeat (7) edge_wait(1'b0, 300);
		rd(OFS_FLAGS);
		chk(rv & 16'h0001, 16'h0000);
		@(posedge clk_sys);
		supply_level <= 5'h18;
		edge_wait(1'b0, 300);
		@(posedge clk_sys);
		supply_level <= 5'h08;
		repeat (7) edge_wait(1'b0, 300);
		rd(OFS_FLAGS);
		chk(rv & 16'h0001, 16'h0000);
		edge_wait(1'b0, 300);
		cyc(4);
		rd(OFS_FLAGS);
		chk(rv & 16'h0001, 16'h0001);
		$display("successive count test done");

		@(posedge clk_sys);
		debug_mode <= 1'b1;
		edge_wait(1'b1, 600);
		chk(16'(n), 16'd600);
		wr(OFS_CLOCK_CTRL, 16'h0160);
		edge_wait(1'b1, 300);
		chk(16'(n < 300), 16'h0001);
		@(posedge clk_sys);
		debug_mode <= 1'b0;
		$display("debug test done");

		wr(OFS_DETECT_CTRL, 16'h7002);
		n = 0;
		do begin
			rd(OFS_DETECT_CTRL);
			n++;
		end while (rv[0] !== 1'b0 && n < 10);
		chk(rv, 16'h7002);
		chk({15'h0000, cmp_enable}, 16'h0000);
		rd(OFS_FLAGS);
		chk(rv & 16'h0001, 16'h0001);
		wr(OFS_PROTECT, 16'h0000);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		rd(OFS_CLOCK_CTRL);
		chk(rv, 16'h0100);
		chk({14'h0000, sys_reset_req, cmp_enable}, 16'h0000);
		$display("disable and reset test done");
		end_of_test;
	end
endmodule
